// [pkg/lane_status_defines.vh]
// How it works
// - Writing 1 to control bit 7 clears the addressed lane's interrupt.
// - Writing 1 to control bit 6 disables the addressed lane's counter.
// - Writing 1 to control bit 5 zeroes the addressed lane's counter.
// - Control bits 2:0 select the lane; bits 4:3 are reserved.
// - Code-group lock register shows live lock bits for lanes 1 and 3-7.
// - Bit 0 of code-group register shows the code-group interrupt.
// - Any lane losing code-group lock raises the sync request.
// - Frame lock register shows live frame lock per lane.
// - Losing frame lock starts a new link sync on its own.
// - Writing 1 to bit 7 of a status register clears its interrupt.
// - Checksum register shows per-lane good-checksum status.
// - Alignment register shows per-lane lane-alignment success.
// - Checksum and alignment interrupts show in code-group bit 2.
// - Loss of lane alignment also raises the sync request.
// - Octets per frame accepts only 1, 2, 4; resets to 1.
// - Test mode bit makes the receiver expect alignment frames always.
// - Multiframe count sets groups of 4K alignment frames; resets to 1.
// - Interrupt vector bit 7 is the read-only disparity flag.
// - Disparity flag sets when any lane count reaches the limit.
// - Control-character flag rises when any lane count hits limit.
`ifndef LANE_STATUS_DEFINES_VH
`define LANE_STATUS_DEFINES_VH

`define ADDR_UNEXP_CTRL   12'h46f
`define ADDR_CG_LOCK      12'h470
`define ADDR_FRAME_LOCK   12'h471
`define ADDR_CHECKSUM     12'h472
`define ADDR_ALIGN        12'h473
`define ADDR_OCTETS       12'h476
`define ADDR_TEST_MASK    12'h477
`define ADDR_MF_COUNT     12'h478
`define ADDR_IRQ_VECTOR   12'h47a

`define BIT_IRQ_CLEAR     7
`define BIT_CNT_DISABLE   6
`define BIT_CNT_CLEAR     5
`define BIT_CG_IRQ        0
`define BIT_CK_AL_IRQ     2
`define BIT_TEST_MODE     7
`define BIT_MASK_EN       3
`define BIT_DISP_FLAG     7
`define BIT_UNEXP_FLAG    5

`define RST_OCTETS        8'h01
`define RST_MF_COUNT      8'h01
`define RST_ZERO          8'h00

`endif

// [rtl/lane_status_monitor.v]
`timescale 1ns/1ps
`default_nettype none
`include "lane_status_defines.vh"

module lane_status_monitor #(
	parameter LANES   = 8,
	parameter CNT_W   = 8
) (
	input  wire             clock,
	input  wire             sys_rst,
	input  wire [11:0]      reg_addr,
	input  wire [7:0]       reg_wdata,
	input  wire             reg_wr,
	input  wire             reg_rd,
	output reg  [7:0]       reg_rdata,
	input  wire [LANES-1:0] code_group_lock,
	input  wire [LANES-1:0] frame_lock,
	input  wire [LANES-1:0] checksum_ok,
	input  wire [LANES-1:0] lane_alignment_ok,
	input  wire [LANES-1:0] unexpected_ctrl_char,
	input  wire [LANES-1:0] disparity_error,
	input  wire [CNT_W-1:0] error_limit,
	output reg              sync_request_output,
	output reg              resync_start,
	output reg  [7:0]       octets_per_frame,
	output reg              alignment_test_mode,
	output reg              threshold_mask_en,
	output reg  [7:0]       alignment_multiframe_count,
	output reg              disparity_error_flag,
	output reg              unexpected_ctrl_flag
);

	// One-hot lane decode, shared by all three lane actions
	function [LANES-1:0] lane_hot;
		input [2:0] sel;
		begin
			lane_hot = {LANES{1'b0}};
			lane_hot[sel] = 1'b1;
		end
	endfunction

	wire wr_ctrl = reg_wr && (reg_addr == `ADDR_UNEXP_CTRL);
	wire [2:0] target_lane_select = reg_wdata[2:0];
	wire [LANES-1:0] target_hot = lane_hot(target_lane_select);
	wire lane_irq_clear =
		wr_ctrl && reg_wdata[`BIT_IRQ_CLEAR];
	wire lane_counter_disable = reg_wdata[`BIT_CNT_DISABLE];
	wire lane_counter_clear =
		wr_ctrl && reg_wdata[`BIT_CNT_CLEAR];

	wire clr_cg = reg_wr && (reg_addr == `ADDR_CG_LOCK) &&
		reg_wdata[`BIT_IRQ_CLEAR];
	wire clr_fr = reg_wr && (reg_addr == `ADDR_FRAME_LOCK) &&
		reg_wdata[`BIT_IRQ_CLEAR];
	wire clr_ck = reg_wr && (reg_addr == `ADDR_CHECKSUM) &&
		reg_wdata[`BIT_IRQ_CLEAR];
	wire clr_al = reg_wr && (reg_addr == `ADDR_ALIGN) &&
		reg_wdata[`BIT_IRQ_CLEAR];

	reg  [LANES-1:0] cg_prev_reg;
	reg  [LANES-1:0] fr_prev_reg;
	reg  [LANES-1:0] ck_prev_reg;
	reg  [LANES-1:0] al_prev_reg;
	reg              cg_irq_reg;
	reg              fr_irq_reg;
	reg              ck_irq_reg;
	reg              al_irq_reg;
	reg  [LANES-1:0] cnt_off_reg;
	reg  [LANES-1:0] unexp_irq_reg;
	wire [LANES-1:0] unexp_hit;
	wire [LANES-1:0] disp_hit;

	// Falling edges of lane status mark a loss
	wire cg_loss = |(cg_prev_reg & ~code_group_lock);
	wire fr_loss = |(fr_prev_reg & ~frame_lock);
	wire ck_loss = |(ck_prev_reg & ~checksum_ok);
	wire al_loss = |(al_prev_reg & ~lane_alignment_ok);

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cg_prev_reg <= {LANES{1'b0}};
			fr_prev_reg <= {LANES{1'b0}};
			ck_prev_reg <= {LANES{1'b0}};
			al_prev_reg <= {LANES{1'b0}};
		end else begin
			cg_prev_reg <= code_group_lock;
			fr_prev_reg <= frame_lock;
			ck_prev_reg <= checksum_ok;
			al_prev_reg <= lane_alignment_ok;
		end
	end

	// Set beats clear so a loss in the clearing cycle is kept
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cg_irq_reg <= 1'b0;
			fr_irq_reg <= 1'b0;
			ck_irq_reg <= 1'b0;
			al_irq_reg <= 1'b0;
		end else begin
			cg_irq_reg <= cg_loss | (cg_irq_reg & ~clr_cg);
			fr_irq_reg <= fr_loss | (fr_irq_reg & ~clr_fr);
			ck_irq_reg <= ck_loss | (ck_irq_reg & ~clr_ck);
			al_irq_reg <= al_loss | (al_irq_reg & ~clr_al);
		end
	end

	// Sync request stays up while any lane is unlocked or misaligned
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sync_request_output <= 1'b1;
			resync_start <= 1'b0;
		end else begin
			sync_request_output <= ~(&code_group_lock) |
				~(&lane_alignment_ok);
			resync_start <= fr_loss;
		end
	end

	// Disable latch: each control write rewrites the addressed lane's bit
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_off_reg <= {LANES{1'b0}};
		end else if (wr_ctrl) begin
			cnt_off_reg <= (cnt_off_reg & ~target_hot) |
				(target_hot & {LANES{lane_counter_disable}});
		end
	end

	genvar i;
	generate
		for (i = 0; i < LANES; i = i + 1) begin : g_lane
			reg [CNT_W-1:0] unexp_cnt_reg;
			reg [CNT_W-1:0] disp_cnt_reg;
			// Counters saturate so a flood cannot wrap below the limit
			always @(posedge clock or posedge sys_rst) begin
				if (sys_rst) begin
					unexp_cnt_reg <= {CNT_W{1'b0}};
				end else if (lane_counter_clear && target_hot[i]) begin
					unexp_cnt_reg <= {CNT_W{1'b0}};
				end else if (unexpected_ctrl_char[i] && !cnt_off_reg[i] &&
						!(&unexp_cnt_reg)) begin
					unexp_cnt_reg <= unexp_cnt_reg + 1'b1;
				end
			end
			always @(posedge clock or posedge sys_rst) begin
				if (sys_rst) begin
					disp_cnt_reg <= {CNT_W{1'b0}};
				end else if (disparity_error[i] && !(&disp_cnt_reg)) begin
					disp_cnt_reg <= disp_cnt_reg + 1'b1;
				end
			end
			assign unexp_hit[i] = (unexp_cnt_reg >= error_limit);
			assign disp_hit[i] = (disp_cnt_reg >= error_limit);
			always @(posedge clock or posedge sys_rst) begin
				if (sys_rst) begin
					unexp_irq_reg[i] <= 1'b0;
				end else begin
					unexp_irq_reg[i] <= unexp_hit[i] |
						(unexp_irq_reg[i] &
						~(lane_irq_clear & target_hot[i]));
				end
			end
		end
	endgenerate

	// Flags follow the sticky lane bits and counter levels
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			disparity_error_flag <= 1'b0;
			unexpected_ctrl_flag <= 1'b0;
		end else begin
			disparity_error_flag <= |disp_hit;
			unexpected_ctrl_flag <= |unexp_irq_reg;
		end
	end

	// Configuration registers
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			octets_per_frame <= `RST_OCTETS;
			alignment_test_mode <= 1'b0;
			threshold_mask_en <= 1'b0;
			alignment_multiframe_count <= `RST_MF_COUNT;
		end else if (reg_wr) begin
			case (reg_addr)
			`ADDR_OCTETS: begin
				// Other frame sizes are dropped, keeping the last good one
				if (reg_wdata == 8'h01 || reg_wdata == 8'h02 ||
						reg_wdata == 8'h04) begin
					octets_per_frame <= reg_wdata;
				end
			end
			`ADDR_TEST_MASK: begin
				alignment_test_mode <= reg_wdata[`BIT_TEST_MODE];
				threshold_mask_en <= reg_wdata[`BIT_MASK_EN];
			end
			`ADDR_MF_COUNT: begin
				alignment_multiframe_count <= reg_wdata;
			end
			default: begin
			end
			endcase
		end
	end

	// Read mux; reserved and unmapped bits read zero
	reg [7:0] rd_next;
	always @* begin
		rd_next = `RST_ZERO;
		case (reg_addr)
		`ADDR_UNEXP_CTRL: rd_next = unexp_irq_reg;
		`ADDR_CG_LOCK: begin
			rd_next = code_group_lock;
			rd_next[`BIT_CG_IRQ] = cg_irq_reg;
			rd_next[`BIT_CK_AL_IRQ] = ck_irq_reg | al_irq_reg;
		end
		`ADDR_FRAME_LOCK: rd_next = frame_lock;
		`ADDR_CHECKSUM: rd_next = checksum_ok;
		`ADDR_ALIGN: rd_next = lane_alignment_ok;
		`ADDR_OCTETS: rd_next = octets_per_frame;
		`ADDR_TEST_MASK: begin
			rd_next[`BIT_TEST_MODE] = alignment_test_mode;
			rd_next[`BIT_MASK_EN] = threshold_mask_en;
		end
		`ADDR_MF_COUNT: rd_next = alignment_multiframe_count;
		`ADDR_IRQ_VECTOR: begin
			rd_next[`BIT_DISP_FLAG] = disparity_error_flag;
			rd_next[`BIT_UNEXP_FLAG] = unexpected_ctrl_flag;
		end
		default: rd_next = `RST_ZERO;
		endcase
	end

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= `RST_ZERO;
		end else if (reg_rd) begin
			reg_rdata <= rd_next;
		end else begin
			reg_rdata <= `RST_ZERO;
		end
	end

endmodule // lane_status_monitor

`default_nettype wire

// [bench/lane_status_checker_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lane_status_defines.vh"
module lane_status_checker #(parameter LANES = 8, parameter CNT_W = 8) (
	input wire logic		clock,
	input wire logic		sys_rst,
	input wire logic [11:0]		reg_addr,
	input wire logic [7:0]		reg_wdata,
	input wire logic		reg_wr,
	input wire logic		reg_rd,
	input wire logic [7:0]		reg_rdata,
	input wire logic [LANES-1:0]	code_group_lock,
	input wire logic [LANES-1:0]	frame_lock,
	input wire logic		sync_request_output,
	input wire logic		resync_start,
	input wire logic [7:0]		octets_per_frame,
	input wire logic		alignment_test_mode,
	input wire logic [7:0]		alignment_multiframe_count
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Own copy of lane history; first edge after reset is masked off
	logic [LANES-1:0]	fl_q;
	always @(posedge clock) fl_q <= frame_lock;
	a_sync_lock: assert property (!(&code_group_lock) |=> sync_request_output)
		else $error("sync request missing");
	a_resync_pulse: assert property (!$past(sys_rst) && |(fl_q & ~frame_lock)
		|=> resync_start) else $error("resync pulse missing");
	a_octets_legal: assert property (octets_per_frame inside {1, 2, 4})
		else $error("octets value illegal");
	a_octets_keep: assert property (reg_wr && reg_addr == `ADDR_OCTETS
		&& !(reg_wdata inside {1, 2, 4}) |=> $stable(octets_per_frame))
		else $error("bad octets taken");
	a_mode_write: assert property (reg_wr && reg_addr == `ADDR_TEST_MASK
		|=> alignment_test_mode == $past(reg_wdata[7])) else $error("mode lost");
	a_count_write: assert property (reg_wr && reg_addr == `ADDR_MF_COUNT
		|=> alignment_multiframe_count == $past(reg_wdata)) else $error("count lost");
	a_frame_read: assert property (reg_rd && reg_addr == `ADDR_FRAME_LOCK
		|=> reg_rdata == $past(frame_lock)) else $error("frame read wrong");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
	cover property (resync_start);
	cover property (sync_request_output ##1 !sync_request_output);
	cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule // lane_status_checker
`default_nettype wire

// [bench/link_tx_model.sv]
`timescale 1ns/1ps
`default_nettype none
module link_tx_model (
	input wire logic	clock,
	input wire logic [5:0]	which,
	input wire logic [7:0]	drop,
	output var logic [7:0]	code_group_lock,
	output var logic [7:0]	frame_lock,
	output var logic [7:0]	checksum_ok,
	output var logic [7:0]	lane_alignment_ok,
	output var logic [7:0]	unexpected_ctrl_char,
	output var logic [7:0]	disparity_error
);
	// Frame size and alignment length fixed at receiver defaults
	always @(posedge clock) begin
		code_group_lock <= ~(drop & {8{which[0]}});
		frame_lock <= ~(drop & {8{which[1]}});
		checksum_ok <= ~(drop & {8{which[2]}});
		lane_alignment_ok <= ~(drop & {8{which[3]}});
		unexpected_ctrl_char <= drop & {8{which[4]}};
		disparity_error <= drop & {8{which[5]}};
	end
endmodule // link_tx_model
`default_nettype wire

// [bench/test_serial_link_lane_status_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lane_status_defines.vh"
module test_serial_link_lane_status_monitor;
	logic		clock, sys_rst, reg_wr, reg_rd, resync_start, sync_request_output;
	logic		alignment_test_mode, threshold_mask_en;
	logic		disparity_error_flag, unexpected_ctrl_flag;
	logic [5:0]	which;
	logic [11:0]	reg_addr;
	logic [7:0]	reg_wdata, reg_rdata, error_limit, drop, octets_per_frame;
	logic [7:0]	code_group_lock, frame_lock, checksum_ok, lane_alignment_ok;
	logic [7:0]	unexpected_ctrl_char, disparity_error, alignment_multiframe_count;
	int		n_errors = 0, checked = 0;
	lane_status_monitor uut (.*);
	link_tx_model tx (.*);
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task chk(input string n, input logic [7:0] s, e);
		checked++;
		if (s !== e) n_errors++;
		if (s !== e) $display("[FAIL] %s expected %h seen %h", n, e, s);
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [7:0] v);
		@(posedge clock);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, v};
		@(posedge clock);
		{reg_wr, reg_rd} <= 2'b00;
		#1;
		if (!w) chk($sformatf("reg %h", a), reg_rdata, v);
	endtask
	// Pulse kinds run until released, so one burst is four characters
	task drive(input logic [5:0] w, input logic [7:0] m);
		@(posedge clock);
		{which, drop} <= {w, m};
		repeat (3) @(posedge clock);
		#1;
	endtask
	task t_config;
		bus(0, `ADDR_OCTETS, 8'h01);
		bus(0, `ADDR_MF_COUNT, 8'h01);
		bus(1, `ADDR_MF_COUNT, 8'h04);
		bus(0, `ADDR_MF_COUNT, 8'h04);
		bus(1, `ADDR_OCTETS, 8'h03);
		bus(0, `ADDR_OCTETS, 8'h01);
		bus(1, `ADDR_OCTETS, 8'h04);
		bus(0, `ADDR_OCTETS, 8'h04);
		bus(1, `ADDR_OCTETS, 8'h05);
		bus(0, `ADDR_OCTETS, 8'h04);
		bus(1, `ADDR_TEST_MASK, 8'hff);
		bus(0, `ADDR_TEST_MASK, 8'h88);
		chk("pins", {6'h0, alignment_test_mode, threshold_mask_en}, 8'h03);
		bus(0, 12'h400, 8'h00);
	endtask
	task t_lanes;
		drive(6'h10, 8'h08);
		drive(6'h00, 8'h00);
		bus(0, `ADDR_IRQ_VECTOR, 8'h20);
		// Counter first: a clear while the count still hits is re-set
		bus(1, `ADDR_UNEXP_CTRL, 8'h23);
		bus(0, `ADDR_UNEXP_CTRL, 8'h08);
		bus(1, `ADDR_UNEXP_CTRL, 8'hbb);
		bus(0, `ADDR_UNEXP_CTRL, 8'h00);
		bus(1, `ADDR_UNEXP_CTRL, 8'h43);
		drive(6'h10, 8'h08);
		drive(6'h00, 8'h00);
		bus(0, `ADDR_IRQ_VECTOR, 8'h00);
		bus(1, `ADDR_UNEXP_CTRL, 8'h03);
		drive(6'h01, 8'h20);
		chk("sync", {7'h00, sync_request_output}, 8'h01);
		bus(0, `ADDR_CG_LOCK, 8'hdb);
		bus(1, `ADDR_CG_LOCK, 8'h80);
		bus(0, `ADDR_CG_LOCK, 8'hda);
		drive(6'h0a, 8'h01);
		chk("sync al", {7'h00, sync_request_output}, 8'h01);
		bus(0, `ADDR_FRAME_LOCK, 8'hfe);
		bus(0, `ADDR_CG_LOCK, 8'hfe);
		bus(1, `ADDR_ALIGN, 8'h80);
		bus(0, `ADDR_CG_LOCK, 8'hfa);
		drive(6'h20, 8'h01);
		drive(6'h00, 8'h00);
		chk("sync off", {7'h00, sync_request_output}, 8'h00);
		bus(0, `ADDR_IRQ_VECTOR, 8'h80);
	endtask
	initial begin
		{sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 20'h0};
		{which, drop, error_limit} = {14'h0, 8'h03};
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		t_config;
		t_lanes;
		stop_test;
	end
	initial begin
		#300000 n_errors++;
		stop_test;
	end
	task stop_test;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
endmodule // test_serial_link_lane_status_monitor
bind lane_status_monitor lane_status_checker
	#(.LANES(LANES), .CNT_W(CNT_W)) chk_i (.*);
`default_nettype wire
